/* File: logic/csr_params.svh */
// Constants of the codec serial control register block.
// Notes on behaviour
// [R1] Each access is one 14-bit word led by a 2-bit instruction field.
// [R2] Instruction 10 reads, 11 writes, any other value does nothing.
// [R3] Then 3-bit address MSB first, one unused bit, data bits 7 down to 0.
// [R4] The unused bit gives one clock to turn the data line around.
// [R5] Serial input bits are sampled on each rising serial clock edge.
// [R6] Rising edges are counted from the falling edge of the select.
// [R7] A write loads the addressed register at the 14th counted rising edge.
// [R8] A read releases the data line at the falling edge of pulse 14.
// [R9] Select rising before the 14th rising edge abandons the write.
// [R10] Select rising before the 14th falling edge abandons the read.
// [R11] The host raises select between accesses; no back-to-back words.
// [R12] Mute pin high: PCM output high impedance, analog output at ground.
// [R13] Mute register bit tristates PCM; the pin alone forces analog ground.
// [R14] Gain code 000..011 gives 0..-9 dB, top bit set gives -12 dB.
// [R15] Key codes: digits binary, 0=1010, star 1011, hash 1100, A-C, D=0000.
// [R16] Key code outputs are high impedance unless the enable pin is 1.
// [R17] Present guard is 1 ms plus 8 ms per step, default code 0100.
// [R18] Absent guard uses the same scale, default code 0010.
// [R19] Tone frequency bit selects 400 Hz at 0 and 1300 Hz at 1.
// [R20] Nine routing bits connect tone sources to outputs, all 0 at reset.
// [R21] Tone enable pin passes the tone at 1, forces ground at 0.
// [R22] Registers are initialised only by the power-on reset.
// [R23] All seven registers at addresses 000 to 110 are read and written.
// [R24] A read drives the eight data bits MSB first after the unused bit.
// [R25] Interface select: 00 non-multiplexed, 01 multiplexed, 10 GCI, 11 IDL.
// [R26] Companding bit selects A-law at 0, mu-law at 1, reset value 1.
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

`define CSR_WORD_BITS     4'd14
`define CSR_ADDR_DONE     4'd5
`define CSR_FIRST_DRIVE   4'd6
`define CSR_INSTR_READ    2'h2
`define CSR_INSTR_WRITE   2'h3
`define CSR_NUM_REGS      3'd7

`define CSR_ADDR_CH0_GAIN 3'h0
`define CSR_ADDR_CH1_GAIN 3'h1
`define CSR_ADDR_TONE_OUT 3'h2
`define CSR_ADDR_TONE_RX  3'h3
`define CSR_ADDR_IF_PWR   3'h4
`define CSR_ADDR_TONE_MUT 3'h5
`define CSR_ADDR_GUARD    3'h6

`define CSR_RST_CH0_GAIN  8'h00
`define CSR_RST_CH1_GAIN  8'h00
`define CSR_RST_TONE_OUT  8'h00
`define CSR_RST_TONE_RX   8'h00
`define CSR_RST_IF_PWR    8'h00
`define CSR_RST_TONE_MUT  8'h10
`define CSR_RST_GUARD     8'h24

`define CSR_GUARD_BASE_MS 7'd1
`define CSR_GUARD_STEP_MS 7'd8

`endif

/* File: logic/csr_pkg.sv */
// Types shared by the codec serial control register block.
`default_nettype none
package csr_pkg;
    typedef struct packed {
        logic sclk;
        logic csN;
        logic data;
    } csr_serial_in_s;

    typedef struct packed {
        logic data;
        logic dataOeN;
    } csr_serial_out_s;

    typedef enum logic [1:0] {
        CSR_IDLE,
        CSR_SHIFT,
        CSR_DONE
    } csr_phase_e;

    typedef logic [6:0][7:0] csr_bank_t;
endpackage : csr_pkg
`default_nettype wire

/* File: logic/csr_reg_mem.sv */
// Seven-byte register store with registered read data.
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"
module csr_reg_mem (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          wrEn,
    input  wire logic [2:0]    wrAddr,
    input  wire logic [7:0]    wrData,
    input  wire logic [2:0]    rdAddr,
    output var  logic [7:0]    rdData,
    output var  csr_pkg::csr_bank_t bank
);
    import csr_pkg::*;

    typedef struct packed {
        csr_bank_t  mem;
        logic [7:0] rd;
    } csr_mem_s;

    csr_mem_s memReg;
    csr_mem_s memNext;

    always_comb begin
        memNext = memReg;
        if (wrEn && (wrAddr < `CSR_NUM_REGS)) begin
            memNext.mem[wrAddr] = wrData; // [R7] [R23]
        end
        // An unmapped address reads as zero.
        if (rdAddr < `CSR_NUM_REGS) begin
            memNext.rd = memReg.mem[rdAddr];
        end else begin
            memNext.rd = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            memReg.mem[0] <= `CSR_RST_CH0_GAIN; // [R22]
            memReg.mem[1] <= `CSR_RST_CH1_GAIN;
            memReg.mem[2] <= `CSR_RST_TONE_OUT;
            memReg.mem[3] <= `CSR_RST_TONE_RX;
            memReg.mem[4] <= `CSR_RST_IF_PWR;
            memReg.mem[5] <= `CSR_RST_TONE_MUT;
            memReg.mem[6] <= `CSR_RST_GUARD;
            memReg.rd     <= 8'h00;
        end else begin
            memReg <= memNext;
        end
    end

    assign rdData = memReg.rd;
    assign bank   = memReg.mem;
endmodule : csr_reg_mem
`default_nettype wire

/* File: logic/csr_serial_regs.sv */
// Serial register port and control outputs of the dual codec.
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"
module csr_serial_regs (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire csr_pkg::csr_serial_in_s  serialIn,
    output var  csr_pkg::csr_serial_out_s serialOut,
    input  wire logic [1:0]               mutePin,
    input  wire logic                     keyCodeOutputEnable,
    input  wire logic [1:0]               toneOutEnablePin,
    input  wire logic [3:0]               keyId0,
    input  wire logic [3:0]               keyId1,
    output var  logic [7:0]               keyCodeOutputs,
    output var  logic [7:0]               keyCodeOeN,
    output var  logic [1:0]               pcmOutHiZ,
    output var  logic [1:0]               rxAnalogGround,
    output var  logic [1:0]               toneOutGround,
    output var  logic [2:0]               rxGainStep0,
    output var  logic [2:0]               rxGainStep1,
    output var  logic [2:0]               txGainStep0,
    output var  logic [2:0]               txGainStep1,
    output var  logic [2:0]               toneGainStep,
    output var  logic [8:0]               toneRouteSwitches,
    output var  logic [1:0]               toneFreqSelect,
    output var  logic [1:0]               codecPowerdownBit,
    output var  logic [1:0]               detectorPowerdownBit,
    output var  logic [1:0]               ifaceSelect,
    output var  logic                     bChannelSwap,
    output var  logic                     primarySyncSelect,
    output var  logic                     companding,
    output var  logic [6:0]               presentGuardMs,
    output var  logic [6:0]               absentGuardMs
);
    import csr_pkg::*;

    // Gain code to 3 dB attenuation steps.
    function automatic logic [2:0] gainStep(input logic [2:0] code);
        logic [2:0] step;
        step = 3'h0;
        if (code[2]) begin
            step = 3'h4; // [R14]
        end else begin
            step = {1'b0, code[1:0]}; // [R14]
        end
        return step;
    endfunction : gainStep

    // Detected key index to the published output code.
    function automatic logic [3:0] keyCode(input logic [3:0] id);
        logic [3:0] code;
        code = 4'h0;
        case (id)
            4'h0: code = 4'ha; // [R15]
            4'ha: code = 4'hb;
            4'hb: code = 4'hc;
            4'hc: code = 4'hd;
            4'hd: code = 4'he;
            4'he: code = 4'hf;
            4'hf: code = 4'h0;
            default: code = id;
        endcase
        return code;
    endfunction : keyCode

    // Guard time in milliseconds for a 4-bit code.
    function automatic logic [6:0] guardMs(input logic [3:0] code);
        logic [6:0] ms;
        ms = 7'(`CSR_GUARD_BASE_MS + `CSR_GUARD_STEP_MS * {3'h0, code});
        return ms;
    endfunction : guardMs

    typedef struct packed {
        csr_serial_in_s  sSync1;
        csr_serial_in_s  sSync2;
        logic            sclkPrev;
        logic            csPrev;
        logic [1:0]      muteSync1;
        logic [1:0]      muteSync2;
        logic            keyOeSync1;
        logic            keyOeSync2;
        logic [1:0]      toneSync1;
        logic [1:0]      toneSync2;
        csr_phase_e      phase;
        logic [3:0]      count;
        logic [13:0]     shift;
        logic            reading;
        logic [2:0]      rdSel;
        csr_serial_out_s sOut;
        logic [7:0]      keyOut;
        logic [7:0]      keyOeN;
        logic [1:0]      pcmHiZ;
        logic [1:0]      rxGnd;
        logic [1:0]      toneGnd;
        logic [14:0]     gains;
        logic [8:0]      route;
        logic [1:0]      freq;
        logic [1:0]      codecPd;
        logic [1:0]      detPd;
        logic [1:0]      iface;
        logic            swap;
        logic            sync;
        logic            comp;
        logic [6:0]      present;
        logic [6:0]      absent;
    } csr_state_s;

    csr_state_s stReg;
    csr_state_s stNext;

    logic       wrEn;
    logic [2:0] wrAddr;
    logic [7:0] wrData;
    logic [2:0] rdAddr;
    logic [7:0] rdData;
    csr_bank_t  bank;

    logic       sclkRise;
    logic       sclkFall;
    logic       csFall;
    logic [13:0] shifted;
    logic [3:0]  countUp;

    csr_reg_mem u_csr_reg_mem (
        .clk    (clk),
        .nrst   (nrst),
        .wrEn   (wrEn),
        .wrAddr (wrAddr),
        .wrData (wrData),
        .rdAddr (rdAddr),
        .rdData (rdData),
        .bank   (bank)
    );

    // All pins but the key indices are only read after the second sync stage.
    assign sclkRise = stReg.sSync2.sclk && !stReg.sclkPrev;
    assign sclkFall = !stReg.sSync2.sclk && stReg.sclkPrev;
    assign csFall   = !stReg.sSync2.csN && stReg.csPrev; // [R6]
    assign shifted  = {stReg.shift[12:0], stReg.sSync2.data}; // [R5]
    assign countUp  = (stReg.count == 4'hf) ? 4'hf : stReg.count + 4'h1;

    // The write lands on the 14th counted rising edge only.
    assign wrEn   = (stReg.phase == CSR_SHIFT) && !stReg.sSync2.csN && sclkRise
                    && (countUp == `CSR_WORD_BITS)
                    && (shifted[13:12] == `CSR_INSTR_WRITE); // [R2] [R7] [R9]
    assign wrAddr = shifted[11:9]; // [R3]
    assign wrData = shifted[7:0]; // [R3]
    // The shifter keeps moving after the address, so the read address is held apart.
    assign rdAddr = stReg.rdSel; // [R23]

    always_comb begin
        stNext = stReg;
        stNext.sSync1     = serialIn;
        stNext.sSync2     = stReg.sSync1;
        stNext.sclkPrev   = stReg.sSync2.sclk;
        stNext.csPrev     = stReg.sSync2.csN;
        stNext.muteSync1  = mutePin;
        stNext.muteSync2  = stReg.muteSync1;
        stNext.keyOeSync1 = keyCodeOutputEnable;
        stNext.keyOeSync2 = stReg.keyOeSync1;
        stNext.toneSync1  = toneOutEnablePin;
        stNext.toneSync2  = stReg.toneSync1;

        if (stReg.sSync2.csN) begin
            // Select high abandons any word in progress.
            stNext.phase        = CSR_IDLE; // [R9] [R10]
            stNext.count        = 4'h0;
            stNext.reading      = 1'b0;
            stNext.sOut.dataOeN = 1'b1; // [R10]
            stNext.sOut.data    = 1'b0;
        end else begin
            case (stReg.phase)
                CSR_IDLE: begin
                    if (csFall) begin
                        stNext.phase = CSR_SHIFT; // [R6]
                        stNext.count = 4'h0;
                        stNext.shift = 14'h0000;
                    end
                end
                CSR_SHIFT: begin
                    if (sclkRise) begin
                        stNext.shift = shifted; // [R5]
                        stNext.count = countUp; // [R6]
                        if (countUp == `CSR_ADDR_DONE
                            && shifted[4:3] == `CSR_INSTR_READ) begin
                            stNext.reading = 1'b1; // [R1] [R2]
                            stNext.rdSel   = shifted[2:0]; // [R3]
                        end
                        if (countUp == `CSR_WORD_BITS
                            && !stReg.reading) begin
                            // No more words until select rises.
                            stNext.phase = CSR_DONE; // [R11]
                        end
                    end
                    if (sclkFall && stReg.reading) begin
                        if (stReg.count == `CSR_WORD_BITS) begin
                            stNext.sOut.dataOeN = 1'b1; // [R8]
                            stNext.reading      = 1'b0;
                            stNext.phase        = CSR_DONE; // [R11]
                        end else if (stReg.count >= `CSR_FIRST_DRIVE) begin
                            // The unused bit covers the turnaround.
                            stNext.sOut.dataOeN = 1'b0; // [R4]
                            stNext.sOut.data    =
                                rdData[3'(`CSR_WORD_BITS - 4'h1 - stReg.count)]; // [R24]
                        end
                    end
                end
                CSR_DONE: begin
                    stNext.phase = CSR_DONE; // [R11]
                end
                default: begin
                    stNext.phase = CSR_IDLE;
                end
            endcase
        end

        // Control outputs, from the register bank, the mute, tone and key enable pins and the key indices.
        stNext.pcmHiZ  = stReg.muteSync2 | bank[5][3:2]; // [R12] [R13]
        stNext.rxGnd   = stReg.muteSync2; // [R12] [R13]
        stNext.toneGnd = ~stReg.toneSync2; // [R21]
        stNext.keyOut  = {keyCode(keyId1), keyCode(keyId0)}; // [R15]
        stNext.keyOeN  = {8{~stReg.keyOeSync2}}; // [R16]
        stNext.gains   = {gainStep(bank[2][2:0]),
                          gainStep(bank[1][6:4]), gainStep(bank[0][6:4]),
                          gainStep(bank[1][2:0]), gainStep(bank[0][2:0])}; // [R14]
        stNext.route   = {bank[2][6:4], bank[3][6:4], bank[3][2:0]}; // [R20]
        stNext.freq    = bank[5][1:0]; // [R19]
        stNext.comp    = bank[5][4]; // [R26]
        stNext.codecPd = bank[4][1:0];
        stNext.detPd   = bank[4][3:2];
        stNext.sync    = bank[4][4];
        stNext.swap    = bank[4][5];
        stNext.iface   = bank[4][7:6]; // [R25]
        stNext.present = guardMs(bank[6][3:0]); // [R17]
        stNext.absent  = guardMs(bank[6][7:4]); // [R18]
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stReg              <= '0;
            stReg.sSync1.sclk  <= 1'b0;
            stReg.sSync1.csN   <= 1'b1;
            stReg.sSync2.csN   <= 1'b1;
            stReg.csPrev       <= 1'b1;
            stReg.phase        <= CSR_IDLE;
            stReg.sOut.dataOeN <= 1'b1;
            stReg.keyOeN       <= 8'hff;
            stReg.pcmHiZ       <= 2'h3;
            stReg.rxGnd        <= 2'h3;
            stReg.toneGnd      <= 2'h3;
            stReg.comp         <= 1'b1;
            stReg.present      <= 7'h21;
            stReg.absent       <= 7'h11;
        end else begin
            stReg <= stNext;
        end
    end

    assign serialOut            = stReg.sOut;
    assign keyCodeOutputs       = stReg.keyOut;
    assign keyCodeOeN           = stReg.keyOeN;
    assign pcmOutHiZ            = stReg.pcmHiZ;
    assign rxAnalogGround       = stReg.rxGnd;
    assign toneOutGround        = stReg.toneGnd;
    assign rxGainStep0          = stReg.gains[2:0];
    assign rxGainStep1          = stReg.gains[5:3];
    assign txGainStep0          = stReg.gains[8:6];
    assign txGainStep1          = stReg.gains[11:9];
    assign toneGainStep         = stReg.gains[14:12];
    assign toneRouteSwitches    = stReg.route;
    assign toneFreqSelect       = stReg.freq;
    assign codecPowerdownBit    = stReg.codecPd;
    assign detectorPowerdownBit = stReg.detPd;
    assign ifaceSelect          = stReg.iface;
    assign bChannelSwap         = stReg.swap;
    assign primarySyncSelect    = stReg.sync;
    assign companding           = stReg.comp;
    assign presentGuardMs       = stReg.present;
    assign absentGuardMs        = stReg.absent;
endmodule : csr_serial_regs
`default_nettype wire

/* File: tb/csr_serial_regs_sva.sv */
// Concurrent checks on the ports of the serial register block.
`timescale 1ns/1ps
`default_nettype none
module csr_serial_regs_chk (
    input  wire csr_pkg::csr_serial_in_s  serialIn,
    input  wire csr_pkg::csr_serial_out_s serialOut,
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic [1:0]               mutePin,
    input  wire logic [1:0]               toneOutEnablePin,
    input  wire logic                     keyCodeOutputEnable,
    input  wire logic [3:0]               keyId0,
    input  wire logic [3:0]               keyId1,
    input  wire logic [7:0]               keyCodeOutputs,
    input  wire logic [7:0]               keyCodeOeN,
    input  wire logic [1:0]               pcmOutHiZ,
    input  wire logic [1:0]               rxAnalogGround,
    input  wire logic [1:0]               toneOutGround,
    input  wire logic [2:0]               rxGainStep0,
    input  wire logic [2:0]               toneGainStep,
    input  wire logic [6:0]               presentGuardMs,
    input  wire logic [6:0]               absentGuardMs
);
    import csr_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    function automatic logic [3:0] code(input logic [3:0] k);
        return (k == 4'h0) ? 4'ha : ((k > 4'h9) ? k + 4'h1 : k);
    endfunction : code

    sequence selRise;
        $rose(serialIn.csN);
    endsequence
    // Read data leaves three clocks after the pin fall, so five low samples
    // are enough for it to settle while the serial clock is still low.
    sequence sclkLow;
        !serialIn.sclk [*5];
    endsequence

    // Pins pass a synchroniser, so mute, tone and key enable relations are judged only once those pins held still.
    chk_line_release: assert property (selRise |-> ##[1:6] serialOut.dataOeN)
        else $error("data line still driven after select rose");
    chk_drive_start: assert property (
        $fell(serialOut.dataOeN) |-> !serialIn.csN && !serialIn.sclk)
        else $error("data line driven outside a read slot");
    chk_data_hold: assert property (
        sclkLow |-> $stable(serialOut.data) || serialOut.dataOeN)
        else $error("read data changed without a clock fall");
    chk_key_code: assert property (
        $past(nrst) |=> keyCodeOutputs == {code($past(keyId1)), code($past(keyId0))})
        else $error("key code wrong");
    chk_key_enable: assert property (keyCodeOutputEnable [*6] |-> keyCodeOeN == 8'h00)
        else $error("key outputs not enabled");
    chk_key_disable: assert property (!keyCodeOutputEnable [*6] |-> keyCodeOeN == 8'hff)
        else $error("key outputs not released");
    chk_mute_ground: assert property ($stable(mutePin) [*6] |->
        rxAnalogGround == mutePin && (pcmOutHiZ & mutePin) == mutePin)
        else $error("mute pin not obeyed");
    chk_tone_ground: assert property (
        $stable(toneOutEnablePin) [*6] |-> toneOutGround == ~toneOutEnablePin)
        else $error("tone ground wrong");
    chk_guard_scale: assert property (
        presentGuardMs[2:0] == 3'h1 && absentGuardMs[2:0] == 3'h1)
        else $error("guard time off the step scale");
    chk_gain_range: assert property (rxGainStep0 <= 3'h4 && toneGainStep <= 3'h4)
        else $error("gain step out of range");
endmodule : csr_serial_regs_chk

bind csr_serial_regs csr_serial_regs_chk u_chk (.clk(clk), .nrst(nrst), .serialIn(serialIn),
    .serialOut(serialOut), .mutePin(mutePin), .toneOutEnablePin(toneOutEnablePin),
    .keyCodeOutputEnable(keyCodeOutputEnable), .keyId0(keyId0), .keyId1(keyId1),
    .keyCodeOutputs(keyCodeOutputs), .keyCodeOeN(keyCodeOeN), .pcmOutHiZ(pcmOutHiZ),
    .rxAnalogGround(rxAnalogGround), .toneOutGround(toneOutGround),
    .rxGainStep0(rxGainStep0), .toneGainStep(toneGainStep),
    .presentGuardMs(presentGuardMs), .absentGuardMs(absentGuardMs));
`default_nettype wire

/* File: tb/csr_host_model.sv */
// Host side of the three-wire serial port.
`timescale 1ns/1ps
`default_nettype none
module csr_host_model (
    input  wire logic                     clk,
    input  wire csr_pkg::csr_serial_out_s serialOut,
    output var  csr_pkg::csr_serial_in_s  serialIn
);
    import csr_pkg::*;
    logic sclk = 1'b0;
    logic csN = 1'b1;
    logic hostData = 1'b0;
    logic lineFree = 1'b1;

    // The line has no pull, so once released it shows a toggling host value.
    assign serialIn = '{sclk: sclk, csN: csN, data: serialOut.dataOeN ? hostData : serialOut.data};

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask : hold

    // Six-clock half periods keep the serial clock under 4 MHz behind the synchronisers.
    task automatic xfer(input logic [13:0] word, input int nBits, output logic [7:0] rd);
        rd = 8'h00;
        csN <= 1'b0;
        hold(6);
        for (int i = 13; i > 13 - nBits; i--) begin
            sclk <= 1'b0;
            hostData <= (word[13:12] == 2'h2 && i < 8) ? ~hostData : word[i];
            hold(6);
            if (i < 8) rd[i] = serialIn.data;
            sclk <= 1'b1;
            hold(6);
        end
        sclk <= 1'b0;
        hold(6);
        // Taken while select is still low, so only the device can have released the line.
        lineFree = serialOut.dataOeN;
        csN <= 1'b1;
        hold(6);
    endtask : xfer
endmodule : csr_host_model
`default_nettype wire

/* File: tb/test_csr_serial_regs.sv */
// Self-checking bench for the codec serial register block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module test_csr_serial_regs;
    import csr_pkg::*;
    localparam logic [7:0] RST [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h24};
    localparam logic [7:0] VAL [7] = '{8'h77, 8'h12, 8'h71, 8'h65, 8'hf9, 8'h1f, 8'hf0};
    logic            clk, nrst, keyOe, swap, sync, companding;
    logic [1:0]      mutePin, toneEn, pcmOutHiZ, rxGnd, toneGnd, freq, codecPd, detPd, iface;
    logic [3:0]      keyId0, keyId1;
    logic [7:0]      keyCodeOutputs, keyCodeOeN, rd;
    logic [2:0]      rx0, rx1, tx0, tx1, toneGain;
    logic [8:0]      routes;
    logic [6:0]      present, absent;
    csr_serial_in_s  serialIn;
    csr_serial_out_s serialOut;
    int              n_mismatch = 0;
    int              checks_done = 0;
    int              cycles = 0;

    csr_serial_regs u_csr_serial_regs (
        .clk(clk), .nrst(nrst), .serialIn(serialIn), .serialOut(serialOut),
        .mutePin(mutePin), .keyCodeOutputEnable(keyOe), .toneOutEnablePin(toneEn),
        .keyId0(keyId0), .keyId1(keyId1), .keyCodeOutputs(keyCodeOutputs),
        .keyCodeOeN(keyCodeOeN), .pcmOutHiZ(pcmOutHiZ), .rxAnalogGround(rxGnd),
        .toneOutGround(toneGnd), .rxGainStep0(rx0), .rxGainStep1(rx1), .txGainStep0(tx0),
        .txGainStep1(tx1), .toneGainStep(toneGain), .toneRouteSwitches(routes),
        .toneFreqSelect(freq), .codecPowerdownBit(codecPd), .detectorPowerdownBit(detPd),
        .ifaceSelect(iface), .bChannelSwap(swap), .primarySyncSelect(sync),
        .companding(companding), .presentGuardMs(present), .absentGuardMs(absent));
    csr_host_model u_csr_host_model (.clk(clk), .serialOut(serialOut), .serialIn(serialIn));

    function automatic logic [3:0] kc(input logic [3:0] k);
        return (k == 4'h0) ? 4'ha : ((k > 4'h9) ? k + 4'h1 : k);
    endfunction : kc

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_csr_host_model.xfer({2'h3, a, 1'b0, d}, 14, rd);
    endtask : wr

    task automatic rdchk(input logic [2:0] a, input logic [7:0] ex);
        u_csr_host_model.xfer({2'h2, a, 1'b0, 8'h00}, 14, rd);
        `CHK("read data", ex, rd)
        `CHK("line free after read", 1'b1, u_csr_host_model.lineFree)
    endtask : rdchk

    task automatic final_report();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // The ceiling is about four times the expected run length.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        nrst = 1'b0;
        keyOe = 1'b0;
        mutePin = 2'h0;
        toneEn = 2'h0;
        keyId0 = 4'h0;
        keyId1 = 4'h0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("reset", {1'b1, 7'd33, 7'd17}, {companding, present, absent})
        for (int i = 0; i < 7; i++) rdchk(3'(i), RST[i]);
        for (int i = 0; i < 7; i++) wr(3'(i), VAL[i]);
        for (int i = 0; i < 7; i++) rdchk(3'(i), VAL[i]);
        rdchk(3'h7, 8'h00);
        `CHK("gains", {3'h4, 3'h4, 3'h2, 3'h1, 3'h1}, {rx0, tx0, rx1, tx1, toneGain})
        `CHK("routing", 9'h1f5, routes)
        `CHK("ctl4", {2'h3, 1'b1, 1'b1, 2'h2, 2'h1}, {iface, swap, sync, detPd, codecPd})
        `CHK("tone ctl", {2'h3, 1'b1}, {freq, companding})
        `CHK("pcm mute", {2'h3, 2'h0}, {pcmOutHiZ, rxGnd})
        `CHK("guards", {7'd1, 7'd121}, {present, absent})
        for (int c = 0; c < 2; c++) begin
            u_csr_host_model.xfer({2'(c), 3'h0, 1'b0, 8'h00}, 14, rd);
        end
        u_csr_host_model.xfer({2'h3, 3'h1, 1'b0, 8'h00}, 13, rd);
        u_csr_host_model.xfer({2'h2, 3'h6, 1'b0, 8'h00}, 10, rd);
        `CHK("line released", 1'b1, serialOut.dataOeN)
        rdchk(3'h0, 8'h77);
        rdchk(3'h1, 8'h12);
        for (int g = 0; g < 8; g++) begin
            wr(3'h1, {5'h00, 3'(g)});
            `CHK("rx gain 1", (g > 3) ? 3'h4 : 3'(g), rx1)
        end
        mutePin <= 2'h1;
        toneEn <= 2'h2;
        keyOe <= 1'b1;
        wr(3'h5, 8'h10);
        `CHK("mute pin", {2'h1, 2'h1, 2'h1}, {pcmOutHiZ, rxGnd, toneGnd})
        for (int k = 0; k < 16; k++) begin
            keyId0 <= 4'(k);
            keyId1 <= 4'(15 - k);
            repeat (2) @(posedge clk);
            `CHK("key codes", {kc(4'(15 - k)), kc(4'(k))}, keyCodeOutputs)
        end
        `CHK("key enables", 8'h00, keyCodeOeN)
        keyOe <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK("key enables", 8'hff, keyCodeOeN)
        final_report();
    end
endmodule : test_csr_serial_regs
`default_nettype wire
